// file: seb_hit_delay.sv
// Programmable delay line for the hit flags and acknowledge.
`timescale 1ns/10ps
module seb_hit_delay
  import seb_pkg::*;
#(
  parameter int W = 4,
  parameter int DEPTH = HIT_DELAY_MAX
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [2:0] sel_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] pipe [DEPTH];
  logic [W-1:0] next_pipe [DEPTH];
  logic [W-1:0] next_q;

  // ----------------------------------------------------------------
  // Shift stages and tap select.
  // ----------------------------------------------------------------
  always_comb begin
    next_q = (sel_i == 3'h0) ? d_i : pipe[sel_i - 3'h1];
  end

  assign next_pipe[0] = d_i;

  for (genvar i = 1; i < DEPTH; i++) begin : g_stage
    assign next_pipe[i] = pipe[i-1];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      q_o <= next_q;
      for (int i = 0; i < DEPTH; i++) begin
        pipe[i] <= next_pipe[i];
      end
    end
  end

  a_delay_tap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (sel_i == 3'h2) [*3] |-> q_o == $past(d_i, 3))
    else $error("Delay line tap two is wrong.");
endmodule : seb_hit_delay

// file: seb_host_model.sv
// Host controller model issuing register reads and writes.
`timescale 1ns/10ps
module seb_host_model
  import seb_pkg::*;
(
  input wire logic ref_clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic [WORD_W-1:0] reg_wdata_o,
  input wire logic [WORD_W-1:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ----------------------------------------------------------------
  // Access tasks; released lines show the inverse of their last value.
  // ----------------------------------------------------------------
  initial begin
    reg_wr_o = 1'h0;
    reg_rd_o = 1'h0;
    reg_addr_o = '0;
    reg_wdata_o = '0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(negedge ref_clk_i);
    reg_wr_o = 1'h1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge ref_clk_i);
    reg_wr_o = 1'h0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d, output logic ok);
    @(negedge ref_clk_i);
    reg_rd_o = 1'h1;
    reg_addr_o = a;
    @(negedge ref_clk_i);
    reg_rd_o = 1'h0;
    reg_addr_o = ~a;
    ok = reg_rvalid_i;
    d = reg_rdata_i;
  endtask : rd
endmodule : seb_host_model

// file: seb_pkg.sv
// Constants shared by the search engine register bank.
package seb_pkg;
  localparam int WORD_W = 72;
  localparam int ADDR_W = 7;
  localparam int IDX_W = 16;
  localparam int NUM_MASK = 32;
  localparam int NUM_RESULT = 8;
  localparam int NUM_PART = 8;
  // Register addresses.
  localparam logic [6:0] ADR_MASK_LO = 7'h20;
  localparam logic [6:0] ADR_MASK_LO_END = 7'h2F;
  localparam logic [6:0] ADR_MASK_HI = 7'h60;
  localparam logic [6:0] ADR_MASK_HI_END = 7'h6F;
  localparam logic [6:0] ADR_RESULT = 7'h30;
  localparam logic [6:0] ADR_RESULT_END = 7'h37;
  localparam logic [6:0] ADR_CONTROL = 7'h38;
  localparam logic [6:0] ADR_INFO = 7'h39;
  localparam logic [6:0] ADR_BURST_RD = 7'h3A;
  localparam logic [6:0] ADR_BURST_WR = 7'h3B;
  localparam logic [6:0] ADR_NEXT_FREE = 7'h3C;
  // Control word fields.
  localparam int CTL_SOFT_RESET_BIT = 0;
  localparam int CTL_OUTPUT_ENABLE_BIT = 1;
  localparam int CTL_TABLE_SIZE_FIELD = 2;
  localparam int CTL_HIT_LATENCY_FIELD = 4;
  localparam int CTL_LAST_IN_CASCADE = 7;
  localparam int CTL_LAST_ON_SRAM_BUS = 8;
  localparam int CTL_CFG = 9;
  localparam int CTL_W = 25;
  localparam logic [1:0] TABLE_SIZE_FIELD_RESET = 2'h1;
  // Result slot and burst pointer fields.
  localparam int RES_VALID = 31;
  localparam int BUR_LEN = 19;
  localparam int BUR_LEN_W = 9;
  // Partition modes and partition select bits of an entry address.
  localparam logic [1:0] CFG_72 = 2'h0;
  localparam logic [1:0] CFG_144 = 2'h1;
  localparam logic [1:0] CFG_288 = 2'h2;
  localparam logic [1:0] CFG_OFF = 2'h3;
  localparam int PART_LO = 13;
  // Latency table in clock cycles.
  localparam logic [2:0] LAT_4 = 3'h4;
  localparam logic [2:0] LAT_5 = 3'h5;
  localparam logic [2:0] LAT_6 = 3'h6;
  // Timing counts and SRAM idle address.
  localparam logic [3:0] SOFT_RST_CYCLES = 4'h8;
  localparam int HIT_DELAY_MAX = 8;
  localparam logic [23:0] SRAM_IDLE_ADDR = 24'hFFFFFF;
endpackage : seb_pkg

// file: seb_register_bank.sv
// Register bank of the cascadable search engine.
//
// What this block does
// - Thirty-two global masks, chosen as sixteen pairs.
// - Mask one compares, mask zero forces match.
// - Mask one writes, mask zero keeps bit.
// - Search names one of eight result registers.
// - Index updates on local or global win.
// - Valid bit set only by global win.
// - Indirect access only with selected valid set.
// - Control bit zero gives eight-cycle reset pulse.
// - Enable bit low releases buses, zeroes cascade.
// - Table size field picks pipeline latency.
// - Hit latency field delays flags and ack.
// - Last device drives miss and idle flags.
// - Last SRAM device drives idle SRAM pins.
// - Two configuration bits per partition.
// - Burst read pointer counts address and length.
// - Burst write pointer counts address and length.
// - Write or learn loads lowest free address.
// - Full output rises when no entry free.
// - Free address even in 144-bit partitions.
// - Speed input flags table size zero as bad latency.
`timescale 1ns/10ps
module seb_register_bank
  import seb_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'hA, // Arbitrary value.
  parameter logic [2:0] IMPLEMENTATION = 3'h5, // Arbitrary value.
  parameter logic [7:0] DEVICE_CODE = 8'h5A, // Arbitrary value.
  parameter logic [15:0] MAKER_CODE = 16'h1234 // Arbitrary value.
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic high_speed_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [WORD_W-1:0] reg_wdata_i,
  output logic [WORD_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [3:0] gm_pair_i,
  input wire logic gm_odd_i,
  input wire logic [WORD_W-1:0] srch_key_i,
  input wire logic [WORD_W-1:0] entry_data_i,
  input wire logic [WORD_W-1:0] entry_mask_i,
  input wire logic [WORD_W-1:0] wr_new_i,
  output logic [WORD_W-1:0] bit_match_o,
  output logic [WORD_W-1:0] wr_merged_o,
  input wire logic srch_done_i,
  input wire logic local_win_i,
  input wire logic global_win_i,
  input wire logic [IDX_W-1:0] hit_index_i,
  input wire logic [2:0] result_sel_i,
  input wire logic ind_acc_i,
  input wire logic [2:0] ind_sel_i,
  output logic ind_grant_o,
  input wire logic sram_rd_ack_i,
  output logic search_hit_flag_o,
  output logic hit_flag_qualifier_o,
  output logic hit_oe_o,
  output logic ack_o,
  input wire logic [2:0] block_hit_i,
  output logic [1:0] local_cascade_hit_out_o,
  output logic [2:0] block_cascade_hit_out_o,
  output logic dq_drive_allow_o,
  input wire logic sram_own_i,
  input wire logic [23:0] sram_addr_i,
  input wire logic [2:0] sram_ctl_n_i,
  input wire logic sram_oe_n_i,
  output logic [23:0] sram_address_o,
  output logic [2:0] sram_ctl_n_o,
  output logic sram_bus_oe_o,
  output logic sram_oe_n_o,
  output logic sram_oe_n_oe_o,
  output logic [2:0] latency_o,
  output logic latency_bad_o,
  output logic [NUM_PART-1:0] part_search_en_o,
  input wire logic burst_rd_step_i,
  input wire logic burst_wr_step_i,
  output logic [IDX_W-1:0] burst_rd_addr_o,
  output logic [IDX_W-1:0] burst_wr_addr_o,
  output logic burst_rd_done_o,
  output logic burst_wr_done_o,
  input wire logic nf_load_i,
  input wire logic nf_found_i,
  input wire logic [IDX_W-1:0] nf_addr_i,
  output logic [1:0] full_out_o
);
  logic speed_meta, speed_sync;
  logic [3:0] soft_reset_bit_cnt, next_soft_reset_bit_cnt;
  logic soft_clr;
  logic [CTL_W-1:1] ctl, next_ctl;
  logic [WORD_W-1:0] global_mask [NUM_MASK];
  logic [4:0] mask_wr_idx;
  logic mask_wr;
  logic [IDX_W-1:0] res_index [NUM_RESULT];
  logic [IDX_W-1:0] next_res_index [NUM_RESULT];
  logic [NUM_RESULT-1:0] res_valid, next_res_valid;
  logic [IDX_W-1:0] brd_addr, next_brd_addr, bwr_addr, next_bwr_addr;
  logic [BUR_LEN_W-1:0] brd_len, next_brd_len, bwr_len, next_bwr_len;
  logic [IDX_W-1:0] nf_addr, next_nf_addr;
  logic nf_full, next_nf_full;
  logic [WORD_W-1:0] next_rdata;
  logic [WORD_W-1:0] gm_sel;
  logic [IDX_W-1:0] hit_index_aligned, nf_aligned;
  logic [1:0] hit_part_mode, nf_part_mode;
  logic [2:0] next_latency;
  logic next_latency_bad;
  logic output_enable_bit, last_in_cascade, last_on_sram_bus, srch_hit;
  logic [3:0] hit_raw, hit_dly;
  logic [NUM_PART-1:0] next_part_en;

  // ----------------------------------------------------------------
  // Speed pin synchroniser and software reset pulse.
  // ----------------------------------------------------------------
  assign soft_clr = (soft_reset_bit_cnt != 4'h0);
  assign output_enable_bit = ctl[CTL_OUTPUT_ENABLE_BIT];
  assign last_in_cascade = ctl[CTL_LAST_IN_CASCADE];
  assign last_on_sram_bus = ctl[CTL_LAST_ON_SRAM_BUS];

  always_comb begin
    next_soft_reset_bit_cnt = soft_clr ? soft_reset_bit_cnt - 4'h1 : soft_reset_bit_cnt;
    if (reg_wr_i && reg_addr_i == ADR_CONTROL && reg_wdata_i[CTL_SOFT_RESET_BIT] && !soft_clr) begin
      next_soft_reset_bit_cnt = SOFT_RST_CYCLES;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      speed_meta <= 1'b0;
      speed_sync <= 1'b0;
      soft_reset_bit_cnt <= 4'h0;
    end else begin
      speed_meta <= high_speed_i;
      speed_sync <= speed_meta;
      soft_reset_bit_cnt <= next_soft_reset_bit_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Control word, burst pointers and next free address.
  // ----------------------------------------------------------------
  assign nf_part_mode = ctl[CTL_CFG + 2*nf_addr_i[IDX_W-1:PART_LO] +: 2];

  always_comb begin
    next_ctl = ctl;
    next_brd_addr = brd_addr;
    next_brd_len = brd_len;
    next_bwr_addr = bwr_addr;
    next_bwr_len = bwr_len;
    next_nf_addr = nf_addr;
    next_nf_full = nf_full;
    nf_aligned = nf_addr_i;
    if (nf_part_mode == CFG_144) begin
      nf_aligned[0] = 1'b0;
    end
    if (burst_rd_step_i && brd_len != '0) begin
      next_brd_addr = brd_addr + 16'h0001;
      next_brd_len = brd_len - 9'h001;
    end
    if (burst_wr_step_i && bwr_len != '0) begin
      next_bwr_addr = bwr_addr + 16'h0001;
      next_bwr_len = bwr_len - 9'h001;
    end
    if (nf_load_i) begin
      next_nf_addr = nf_aligned;
      next_nf_full = !nf_found_i;
    end
    if (reg_wr_i && !soft_clr) begin
      if (reg_addr_i == ADR_CONTROL) begin
        next_ctl = reg_wdata_i[CTL_W-1:1];
      end else if (reg_addr_i == ADR_BURST_RD) begin
        next_brd_addr = reg_wdata_i[IDX_W-1:0];
        next_brd_len = reg_wdata_i[BUR_LEN +: BUR_LEN_W];
      end else if (reg_addr_i == ADR_BURST_WR) begin
        next_bwr_addr = reg_wdata_i[IDX_W-1:0];
        next_bwr_len = reg_wdata_i[BUR_LEN +: BUR_LEN_W];
      end
    end
    if (soft_clr) begin
      next_ctl = '0;
      next_ctl[CTL_TABLE_SIZE_FIELD +: 2] = TABLE_SIZE_FIELD_RESET;
      next_brd_addr = '0;
      next_brd_len = '0;
      next_bwr_addr = '0;
      next_bwr_len = '0;
      next_nf_addr = '0;
      next_nf_full = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl <= '0;
      ctl[CTL_TABLE_SIZE_FIELD +: 2] <= TABLE_SIZE_FIELD_RESET;
      brd_addr <= '0;
      brd_len <= '0;
      bwr_addr <= '0;
      bwr_len <= '0;
      nf_addr <= '0;
      nf_full <= 1'b0;
    end else begin
      ctl <= next_ctl;
      brd_addr <= next_brd_addr;
      brd_len <= next_brd_len;
      bwr_addr <= next_bwr_addr;
      bwr_len <= next_bwr_len;
      nf_addr <= next_nf_addr;
      nf_full <= next_nf_full;
    end
  end

  // ----------------------------------------------------------------
  // Global mask array and its use in search and write.
  // ----------------------------------------------------------------
  always_comb begin
    mask_wr = 1'b0;
    mask_wr_idx = 5'h00;
    if (reg_addr_i >= ADR_MASK_LO && reg_addr_i <= ADR_MASK_LO_END) begin
      mask_wr = reg_wr_i;
      mask_wr_idx = {1'b0, reg_addr_i[3:0]};
    end else if (reg_addr_i >= ADR_MASK_HI && reg_addr_i <= ADR_MASK_HI_END) begin
      mask_wr = reg_wr_i;
      mask_wr_idx = {1'b1, reg_addr_i[3:0]};
    end
  end

  assign gm_sel = global_mask[{gm_pair_i, gm_odd_i}];

  always_ff @(posedge ref_clk_i) begin
    if (mask_wr) begin
      global_mask[mask_wr_idx] <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Result slots.
  // ----------------------------------------------------------------
  assign srch_hit = srch_done_i && (local_win_i || global_win_i);
  assign hit_part_mode = ctl[CTL_CFG + 2*hit_index_i[IDX_W-1:PART_LO] +: 2];

  always_comb begin
    hit_index_aligned = hit_index_i;
    if (hit_part_mode == CFG_144) begin
      hit_index_aligned[0] = 1'b0;
    end else if (hit_part_mode == CFG_288) begin
      hit_index_aligned[1:0] = 2'h0;
    end
  end

  for (genvar r = 0; r < NUM_RESULT; r++) begin : g_result
    always_comb begin
      next_res_index[r] = res_index[r];
      next_res_valid[r] = res_valid[r] && !soft_clr;
      if (srch_hit && result_sel_i == 3'(r)) begin
        next_res_index[r] = hit_index_aligned;
        next_res_valid[r] = global_win_i ? 1'b1 : next_res_valid[r];
      end
    end

    always_ff @(posedge ref_clk_i) begin
      res_index[r] <= next_res_index[r];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_valid <= '0;
    end else begin
      res_valid <= next_res_valid;
    end
  end

  // ----------------------------------------------------------------
  // Read path and registered outputs.
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (reg_addr_i >= ADR_MASK_LO && reg_addr_i <= ADR_MASK_LO_END) begin
      next_rdata = global_mask[{1'b0, reg_addr_i[3:0]}];
    end else if (reg_addr_i >= ADR_MASK_HI && reg_addr_i <= ADR_MASK_HI_END) begin
      next_rdata = global_mask[{1'b1, reg_addr_i[3:0]}];
    end else if (reg_addr_i >= ADR_RESULT && reg_addr_i <= ADR_RESULT_END) begin
      next_rdata[IDX_W-1:0] = res_index[reg_addr_i[2:0]];
      next_rdata[RES_VALID] = res_valid[reg_addr_i[2:0]];
    end else if (reg_addr_i == ADR_CONTROL) begin
      next_rdata[CTL_W-1:0] = {ctl, soft_clr};
    end else if (reg_addr_i == ADR_INFO) begin
      next_rdata[31:0] = {MAKER_CODE, DEVICE_CODE, 1'b0, IMPLEMENTATION, REVISION};
    end else if (reg_addr_i == ADR_BURST_RD) begin
      next_rdata[27:0] = {brd_len, 3'h0, brd_addr};
    end else if (reg_addr_i == ADR_BURST_WR) begin
      next_rdata[27:0] = {bwr_len, 3'h0, bwr_addr};
    end else if (reg_addr_i == ADR_NEXT_FREE) begin
      next_rdata[IDX_W-1:0] = nf_addr;
    end
    next_latency_bad = 1'b0;
    case (ctl[CTL_TABLE_SIZE_FIELD +: 2])
      2'h0: begin
        next_latency = LAT_4;
        next_latency_bad = speed_sync;
      end
      2'h1: next_latency = LAT_5;
      2'h2: next_latency = LAT_6;
      default: begin
        next_latency = LAT_6;
        next_latency_bad = 1'b1;
      end
    endcase
    hit_raw = 4'h0;
    if (output_enable_bit && srch_done_i && global_win_i) begin
      hit_raw = 4'hE;
    end else if (output_enable_bit && last_in_cascade && srch_done_i) begin
      hit_raw = 4'hA;
    end else if (output_enable_bit && last_in_cascade) begin
      hit_raw = 4'h8;
    end
    hit_raw[0] = sram_rd_ack_i;
  end

  for (genvar p = 0; p < NUM_PART; p++) begin : g_part
    assign next_part_en[p] = ctl[CTL_CFG + 2*p +: 2] != CFG_OFF;
  end

  seb_hit_delay #(
    .W(4),
    .DEPTH(HIT_DELAY_MAX)
  ) u_hit_delay (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(hit_raw),
    .sel_i(ctl[CTL_HIT_LATENCY_FIELD +: 3]),
    .q_o(hit_dly)
  );

  assign hit_oe_o = hit_dly[3];
  assign search_hit_flag_o = hit_dly[2];
  assign hit_flag_qualifier_o = hit_dly[1];
  assign ack_o = hit_dly[0];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
      bit_match_o <= '0;
      wr_merged_o <= '0;
      ind_grant_o <= 1'b0;
      local_cascade_hit_out_o <= '0;
      block_cascade_hit_out_o <= '0;
      dq_drive_allow_o <= 1'b0;
      sram_address_o <= SRAM_IDLE_ADDR;
      sram_ctl_n_o <= 3'h7;
      sram_bus_oe_o <= 1'b0;
      sram_oe_n_o <= 1'b1;
      sram_oe_n_oe_o <= 1'b0;
      latency_o <= LAT_5;
      latency_bad_o <= 1'b0;
      part_search_en_o <= '0;
      burst_rd_addr_o <= '0;
      burst_wr_addr_o <= '0;
      burst_rd_done_o <= 1'b1;
      burst_wr_done_o <= 1'b1;
      full_out_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : '0;
      reg_rvalid_o <= reg_rd_i;
      bit_match_o <= ~gm_sel | ~entry_mask_i | ~(srch_key_i ^ entry_data_i);
      wr_merged_o <= (gm_sel & wr_new_i) | (~gm_sel & entry_data_i);
      ind_grant_o <= ind_acc_i && res_valid[ind_sel_i];
      local_cascade_hit_out_o <= {2{output_enable_bit && local_win_i}};
      block_cascade_hit_out_o <= output_enable_bit ? block_hit_i : 3'h0;
      dq_drive_allow_o <= output_enable_bit;
      sram_address_o <= sram_own_i ? sram_addr_i : SRAM_IDLE_ADDR;
      sram_ctl_n_o <= sram_own_i ? sram_ctl_n_i : 3'h7;
      sram_bus_oe_o <= output_enable_bit && (sram_own_i || last_on_sram_bus);
      sram_oe_n_o <= sram_oe_n_i;
      sram_oe_n_oe_o <= output_enable_bit && last_on_sram_bus;
      latency_o <= next_latency;
      latency_bad_o <= next_latency_bad;
      part_search_en_o <= next_part_en;
      burst_rd_addr_o <= brd_addr;
      burst_wr_addr_o <= bwr_addr;
      burst_rd_done_o <= brd_len == '0;
      burst_wr_done_o <= bwr_len == '0;
      full_out_o <= {2{nf_full}};
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  a_soft_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    reg_wr_i && reg_addr_i == ADR_CONTROL && reg_wdata_i[0] && !soft_clr
    |=> soft_clr [*8] ##1 !soft_clr)
    else $error("Software reset pulse is not eight cycles.");
  a_soft_clears: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $fell(soft_clr) |-> ctl[CTL_OUTPUT_ENABLE_BIT] == 1'b0 && ctl[CTL_TABLE_SIZE_FIELD +: 2] == TABLE_SIZE_FIELD_RESET)
    else $error("Software reset left control bits set.");
  a_disable_quiet: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !output_enable_bit ##1 !output_enable_bit |-> local_cascade_hit_out_o == 2'h0 && !sram_bus_oe_o && !dq_drive_allow_o)
    else $error("Disabled device drives its buses.");
  a_valid_global: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (res_valid & ~$past(res_valid)) != '0
    |-> $past(srch_hit && global_win_i)
    && (res_valid & ~$past(res_valid)) == (8'h01 << $past(result_sel_i)))
    else $error("Valid bit set without global win.");
  a_index_load: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    srch_hit |=> res_index[$past(result_sel_i)] == $past(hit_index_aligned))
    else $error("Hit index not stored.");
  a_grant_valid: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ind_grant_o |-> $past(res_valid[ind_sel_i] && ind_acc_i))
    else $error("Indirect access granted without valid bit.");
  a_burst_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    burst_rd_step_i && brd_len != '0 && !reg_wr_i && !soft_clr
    |=> brd_addr == $past(brd_addr) + 16'h0001 && brd_len == $past(brd_len) - 9'h001)
    else $error("Burst read pointer did not step.");
  a_free_even: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    nf_load_i && !soft_clr && nf_part_mode == CFG_144 |=> nf_addr[0] == 1'b0)
    else $error("Free address odd in wide partition.");
  a_idle_sram: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !sram_own_i |=> sram_address_o == SRAM_IDLE_ADDR && sram_ctl_n_o == 3'h7)
    else $error("Idle SRAM pins not driven high.");
  a_miss_flags: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ctl[CTL_HIT_LATENCY_FIELD +: 3] == 3'h0 && output_enable_bit && last_in_cascade && srch_done_i && !global_win_i
    |=> hit_oe_o && !search_hit_flag_o && hit_flag_qualifier_o)
    else $error("Last device miss flags wrong.");
  c_soft_reset: cover property (@(posedge ref_clk_i) $fell(soft_clr));
  c_global_win: cover property (@(posedge ref_clk_i) srch_done_i && global_win_i);
  c_burst_done: cover property (@(posedge ref_clk_i) $rose(burst_rd_done_o));
  c_full: cover property (@(posedge ref_clk_i) $rose(full_out_o[0]));
endmodule : seb_register_bank

// file: seb_register_bank_bench.sv
// Self-checking bench for the search engine register bank.
`timescale 1ns/10ps
module seb_register_bank_bench
  import seb_pkg::*;
;
  localparam logic [15:0] MK = 16'hC0DE; // Arbitrary value.
  localparam logic [7:0] DV = 8'h3C; // Arbitrary value.
  localparam logic [3:0] RV = 4'h2; // Arbitrary value.
  localparam logic [2:0] IM = 3'h3; // Arbitrary value.
  logic ref_clk_i = 1'h0, nrst_i = 1'h0, high_speed_i = 1'h0, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [WORD_W-1:0] reg_wdata_i, reg_rdata_o, srch_key_i = '0, entry_data_i = '1;
  logic [WORD_W-1:0] entry_mask_i = '1, wr_new_i = '0, bit_match_o, wr_merged_o;
  logic [3:0] gm_pair_i = '0;
  logic gm_odd_i = 1'h0, srch_done_i = 1'h0, local_win_i = 1'h0, global_win_i = 1'h0;
  logic ind_acc_i = 1'h0, ind_grant_o, sram_rd_ack_i = 1'h0, sram_own_i = 1'h0;
  logic sram_oe_n_i = 1'h1, nf_load_i = 1'h0, nf_found_i = 1'h0;
  logic burst_rd_step_i = 1'h0, burst_wr_step_i = 1'h0, burst_rd_done_o, burst_wr_done_o;
  logic search_hit_flag_o, hit_flag_qualifier_o, hit_oe_o, ack_o, dq_drive_allow_o;
  logic sram_bus_oe_o, sram_oe_n_o, sram_oe_n_oe_o, latency_bad_o;
  logic [IDX_W-1:0] hit_index_i = '0, nf_addr_i = '0, burst_rd_addr_o, burst_wr_addr_o;
  logic [2:0] result_sel_i = '0, ind_sel_i = '0, block_hit_i = '0, sram_ctl_n_i = '1;
  logic [2:0] latency_o, sram_ctl_n_o, block_cascade_hit_out_o;
  logic [1:0] local_cascade_hit_out_o, full_out_o;
  logic [23:0] sram_addr_i = '0, sram_address_o;
  logic [NUM_PART-1:0] part_search_en_o;
  int failures = 0, samples_checked = 0;
  seb_register_bank #(.REVISION(RV), .IMPLEMENTATION(IM), .DEVICE_CODE(DV), .MAKER_CODE(MK))
    seb_register_bank_i (.ref_clk_i, .nrst_i, .high_speed_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .gm_pair_i, .gm_odd_i, .srch_key_i, .entry_data_i,
    .entry_mask_i, .wr_new_i, .bit_match_o, .wr_merged_o, .srch_done_i, .local_win_i,
    .global_win_i, .hit_index_i, .result_sel_i, .ind_acc_i, .ind_sel_i, .ind_grant_o,
    .sram_rd_ack_i, .search_hit_flag_o, .hit_flag_qualifier_o, .hit_oe_o, .ack_o, .block_hit_i,
    .local_cascade_hit_out_o, .block_cascade_hit_out_o, .dq_drive_allow_o, .sram_own_i,
    .sram_addr_i, .sram_ctl_n_i, .sram_oe_n_i, .sram_address_o, .sram_ctl_n_o, .sram_bus_oe_o,
    .sram_oe_n_o, .sram_oe_n_oe_o, .latency_o, .latency_bad_o, .part_search_en_o,
    .burst_rd_step_i, .burst_wr_step_i, .burst_rd_addr_o, .burst_wr_addr_o, .burst_rd_done_o,
    .burst_wr_done_o, .nf_load_i, .nf_found_i, .nf_addr_i, .full_out_o);
  seb_host_model seb_host_model_i (.ref_clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));
  always #2 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------------------------------
  // Helper tasks.
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [71:0] v);
    seb_host_model_i.wr(a, v);
  endtask : wr
  task automatic rc(input logic [6:0] a, input logic [71:0] exp);
    logic [71:0] d;
    logic ok;
    seb_host_model_i.rd(a, d, ok);
    if (ok !== 1'h1) d = 'x;
    chk(d, exp);
  endtask : rc
  task automatic search(input logic [2:0] s, input logic g, input logic [15:0] x);
    srch_done_i = 1'h1;
    local_win_i = 1'h1;
    global_win_i = g;
    result_sel_i = s;
    hit_index_i = x;
    cyc(1);
    srch_done_i = 1'h0;
    cyc(1);
  endtask : search
  task automatic nf(input logic f, input logic [15:0] x);
    nf_load_i = 1'h1;
    nf_found_i = f;
    nf_addr_i = x;
    cyc(1);
    nf_load_i = 1'h0;
    cyc(1);
  endtask : nf
  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    cyc(8);
    nrst_i = 1'h1;
    chk({66'h0, dq_drive_allow_o, local_cascade_hit_out_o, hit_oe_o, sram_bus_oe_o,
      burst_rd_done_o}, 72'h1);
    rc(ADR_CONTROL, 72'h4);
    rc(ADR_INFO, {40'h0, MK, DV, 1'h0, IM, RV});
    rc(7'h3D, 72'h0);
    wr(ADR_CONTROL, ~72'h1);
    rc(ADR_CONTROL, 72'h1FFFFFE);
    for (int t = 0; t < 4; t++) begin
      wr(ADR_CONTROL, 72'(t * 516 + 2));
      cyc(1);
      chk({63'h0, latency_bad_o, 5'h0, latency_o}, {63'h0, t == 3, 5'h0,
        (t == 3) ? LAT_6 : 3'(4 + t)});
      chk({64'h0, part_search_en_o}, (t == 3) ? 72'hFE : 72'hFF);
    end
    high_speed_i = 1'h1;
    wr(ADR_CONTROL, 72'h2);
    cyc(4);
    chk({71'h0, latency_bad_o}, 72'h1);
    high_speed_i = 1'h0;
    wr(ADR_CONTROL, 72'h806);
    cyc(1);
    chk({71'h0, dq_drive_allow_o}, 72'h1);
    for (int m = 0; m < 32; m++) begin
      wr(7'((m < 16 ? 32 : 80) + m), {9{8'((m / 2) * 17 + 3)}});
    end
    for (int p = 0; p < 16; p++) begin
      gm_pair_i = 4'(p);
      gm_odd_i = p[0];
      cyc(1);
      chk(bit_match_o, ~{9{8'(p * 17 + 3)}});
      chk(wr_merged_o, ~{9{8'(p * 17 + 3)}});
    end
    rc(7'h6F, {9{8'h02}});
    search(3'h3, 1'h1, 16'h1235);
    search(3'h4, 1'h0, 16'h0ABC);
    search(3'h5, 1'h1, 16'h2237);
    rc(7'h33, 72'h80001235);
    rc(7'h34, 72'h0ABC);
    rc(7'h35, 72'h80002236);
    for (int s = 3; s < 5; s++) begin
      ind_acc_i = 1'h1;
      ind_sel_i = 3'(s);
      cyc(1);
      ind_acc_i = 1'h0;
      chk({71'h0, ind_grant_o}, (s == 3) ? 72'h1 : 72'h0);
      cyc(1);
    end
    for (int b = 0; b < 2; b++) begin
      wr(7'(58 + b), 72'h200010);
      burst_rd_step_i = (b == 0);
      burst_wr_step_i = (b == 1);
      cyc(5);
      burst_rd_step_i = 1'h0;
      burst_wr_step_i = 1'h0;
      cyc(2);
      rc(7'(58 + b), 72'h14);
      chk({55'h0, (b == 0) ? burst_rd_done_o : burst_wr_done_o,
        (b == 0) ? burst_rd_addr_o : burst_wr_addr_o}, 72'h10014);
    end
    nf(1'h1, 16'h2005);
    rc(ADR_NEXT_FREE, 72'h2004);
    chk({70'h0, full_out_o}, 72'h0);
    nf(1'h0, 16'h0000);
    chk({70'h0, full_out_o}, 72'h3);
    local_win_i = 1'h0;
    global_win_i = 1'h0;
    block_hit_i = 3'h5;
    for (int h = 0; h < 3; h += 2) begin
      wr(ADR_CONTROL, 72'(h * 16 + 386));
      srch_done_i = 1'h1;
      sram_rd_ack_i = 1'h1;
      cyc(1);
      srch_done_i = 1'h0;
      sram_rd_ack_i = 1'h0;
      cyc(h);
      for (int k = 0; k < 2; k++) begin
        chk({39'h0, block_cascade_hit_out_o, sram_address_o, sram_bus_oe_o, sram_oe_n_oe_o,
          hit_oe_o, search_hit_flag_o, hit_flag_qualifier_o, ack_o},
          {39'h0, 3'h5, SRAM_IDLE_ADDR, k ? 6'h38 : 6'h3B});
        cyc(1);
      end
    end
    wr(ADR_CONTROL, 72'h807);
    wr(ADR_CONTROL, 72'h6);
    cyc(10);
    rc(ADR_CONTROL, 72'h4);
    rc(ADR_BURST_RD, 72'h0);
    rc(7'h33, 72'h1235);
    chk({69'h0, block_cascade_hit_out_o}, 72'h0);
    summarize();
  end
endmodule : seb_register_bank_bench
